// >>> include/sps_pkg.sv
/*
  constants, field positions and carrier types for the semaphore-guarded
  serial slave; assumes a 12-bit byte address on the register port
*/
package sps_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_ACQ_TASK = 12'h024;
  localparam logic [11:0] OFS_REL_TASK = 12'h028;
  localparam logic [11:0] OFS_SUB_ACQ = 12'h0A4;
  localparam logic [11:0] OFS_SUB_REL = 12'h0A8;
  localparam logic [11:0] OFS_EV_DONE = 12'h104;
  localparam logic [11:0] OFS_EV_RXF = 12'h110;
  localparam logic [11:0] OFS_EV_OBT = 12'h128;
  localparam logic [11:0] OFS_PUB_DONE = 12'h184;
  localparam logic [11:0] OFS_PUB_RXF = 12'h190;
  localparam logic [11:0] OFS_PUB_OBT = 12'h1A8;
  localparam logic [11:0] OFS_LINKS = 12'h200;
  localparam logic [11:0] OFS_IEN_SET = 12'h304;
  localparam logic [11:0] OFS_IEN_CLR = 12'h308;
  localparam logic [11:0] OFS_SEM_OWNER_STATUS = 12'h400;
  localparam logic [11:0] OFS_XSTAT = 12'h440;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_PSEL_CLK = 12'h508;
  localparam logic [11:0] OFS_PSEL_DOUT = 12'h50C;
  localparam logic [11:0] OFS_PSEL_DIN = 12'h510;
  localparam logic [11:0] OFS_PSEL_SEL = 12'h514;
  localparam logic [11:0] OFS_RX_PTR = 12'h534;
  localparam logic [11:0] OFS_RX_LIM = 12'h538;
  localparam logic [11:0] OFS_RX_CNT = 12'h53C;
  localparam logic [11:0] OFS_RX_LIST = 12'h540;
  localparam logic [11:0] OFS_TX_PTR = 12'h544;
  localparam logic [11:0] OFS_TX_LIM = 12'h548;
  localparam logic [11:0] OFS_TX_CNT = 12'h54C;
  localparam logic [11:0] OFS_TX_LIST = 12'h550;
  localparam logic [11:0] OFS_CONFIG = 12'h554;
  localparam logic [11:0] OFS_IGN_CHAR = 12'h55C;
  localparam logic [11:0] OFS_OVR_CHAR = 12'h5C0;
  localparam logic [11:0] OFS_IRQ_PEND = 12'h600;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h604;
  localparam logic [11:0] OFS_BUF_IDX = 12'h608;
  localparam logic [11:0] OFS_BUF_DATA = 12'h60C;
  localparam int CHANNEL_INDEX_W = 8;
  localparam int CFG_EN_BIT = 31;
  localparam int PSEL_DISC_BIT = 31;
  localparam int LINK_END_ACQ_BIT = 2;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_RXF_BIT = 4;
  localparam int IRQ_OBT_BIT = 10;
  localparam logic [31:0] IRQ_MASK = 32'h00000412;
  localparam logic [31:0] LINKS_MASK = 32'h00000004;
  localparam int XST_OVREAD_BIT = 0;
  localparam int XST_OVFLOW_BIT = 1;
  localparam logic [3:0] ENABLE_ON = 4'h2;
  localparam logic [31:0] RST_PSEL = 32'hFFFFFFFF;
  localparam logic [1:0] SEM_FREE = 2'h0;
  localparam logic [1:0] SEM_CPU = 2'h1;
  localparam logic [1:0] SEM_LINK = 2'h2;
  localparam logic [1:0] SEM_CPU_PEND = 2'h3;
  localparam int PUB_DONE = 0;
  localparam int PUB_RXF = 1;
  localparam int PUB_OBT = 2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [2:0] {
    OWN_FREE = 3'b001,
    OWN_CPU = 3'b010,
    OWN_LINK = 3'b100
  } sps_owner_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } sps_bus_type;
  typedef struct packed {
    logic pulse;
    logic [CHANNEL_INDEX_W-1:0] chan;
  } sps_pub_type;
endpackage : sps_pkg

// >>> design/sps_slave.sv
/*
  serial slave with semaphore-guarded byte buffer, tasks, events,
  subscribe/publish and interrupt; assumes a mode-0, msb-first master
  whose clock is at most an eighth of sys_clk_in
*/
// Local design decision: the strobed register port.
// Notes on behaviour
// - a release task hands a cpu-held semaphore back so the link may take it.
// - the acquire subscription holds a channel index and an enable bit, reset zero.
// - a release subscription lets a channel event release the semaphore.
// - the receive-full event is set once the receive buffer is filled.
// - done, receive-full and obtained events each publish on their own channel.
// - a link register chains the done event straight to the acquire task.
// - an ungranted transaction shifts out the ignored-fill character.
// - the receive limit caps bytes written per granted transaction.
// - the transmit limit caps bytes fetched per granted transaction.
// - rx_count holds the bytes written to the buffer in the last granted transaction.
// - tx_count holds buffer bytes sent in the last granted transaction.
// - the data-output pin select is its own register, decoded alone.
// - select falling tries to take the semaphore; on failure all is ignored.
// - select rising after a granted transaction frees it and raises done.
// - enabling gives the cpu the semaphore silently; the cpu wins races.
// - past the transmit limit the overrun character goes out uncounted.
`timescale 1ns/10ps
`default_nettype none
module sps_slave #(
  parameter int MEM_DEPTH = 256,
  parameter int CNT_W = 8,
  parameter int NUM_CH = 256
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire sps_pkg::sps_bus_type bus_in,
  output logic [31:0] rd_data_out,
  input wire logic [NUM_CH-1:0] chan_evt_in,
  output sps_pkg::sps_pub_type [2:0] pub_out,
  input wire logic sck_in,
  input wire logic chip_select_n_in,
  input wire logic din_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic irq_out
);
  import sps_pkg::*;
  localparam int AW = $clog2(MEM_DEPTH);

  if (MEM_DEPTH < 2 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0 ||
      CNT_W < 1 || CNT_W > AW || NUM_CH < 1 || NUM_CH > 256) begin : g_chk
    $error("sps_slave: unsupported parameter values");
  end

  typedef struct packed {
    logic sck_s1, sck_s2, sck_d;
    logic csn_s1, csn_s2, csn_d;
    logic din_s1, din_s2;
    logic en_d;
    sps_owner_type owner;
    logic pend;
    logic active, granted;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh, tx_sh, tx_next;
    logic from_buf, next_from_buf;
    logic [CNT_W-1:0] rx_cnt, tx_cnt, rx_amt, tx_amt, rx_lim, tx_lim;
    logic [31:0] sub_acq, sub_rel, pub_done, pub_rxf, pub_obt;
    logic [31:0] links, ien, irq_pend;
    logic ev_done, ev_rxf, ev_obt;
    logic [1:0] xstat;
    logic [3:0] enable;
    logic [31:0] psel_clk, psel_dout, psel_din, psel_sel;
    logic [31:0] rx_ptr, tx_ptr;
    logic [1:0] rx_list, tx_list;
    logic [2:0] config_bits;
    logic [7:0] ign_char, ovr_char;
    logic [AW-1:0] buf_idx;
    logic [31:0] rd_data;
    sps_pub_type [2:0] pub;
  } sps_state_type;

  sps_state_type s, n;
  logic [7:0] mem [MEM_DEPTH];
  logic mem_we, mem_we_link;
  logic [AW-1:0] mem_wa, tx_ra;
  logic [7:0] mem_wd;
  logic enabled, linked, csn_eff, en_rise;
  logic cs_fall, cs_rise, sck_rise, sck_fall, byte_done;
  logic done, acq_req, rel_req, obtained, rx_full;
  logic sub_acq_hit, sub_rel_hit;
  logic [CNT_W-1:0] tx_idx;

  function automatic logic sub_hit(input logic [31:0] cfg,
                                   input logic [NUM_CH-1:0] evt);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cfg[CHANNEL_INDEX_W-1:0] == CHANNEL_INDEX_W'(i)) begin
        hit = evt[i];
      end
    end
    return cfg[CFG_EN_BIT] & hit;
  endfunction : sub_hit

  function automatic logic wr_at(input sps_bus_type b,
                                 input logic [ADDR_W-1:0] a);
    return b.wr && b.addr == a;
  endfunction : wr_at

  always_comb begin
    n = s;
    mem_we = 1'b0;
    mem_we_link = 1'b0;
    mem_wa = s.buf_idx;
    mem_wd = bus_in.wdata[7:0];
    obtained = 1'b0;
    rx_full = 1'b0;
    // select and clock pass two flops before any edge logic looks at them
    n.sck_s1 = sck_in;
    n.sck_s2 = s.sck_s1;
    n.csn_s1 = chip_select_n_in;
    n.csn_s2 = s.csn_s1;
    n.din_s1 = din_in;
    n.din_s2 = s.din_s1;
    enabled = s.enable == ENABLE_ON;
    linked = enabled && !s.psel_sel[PSEL_DISC_BIT] &&
             !s.psel_clk[PSEL_DISC_BIT];
    csn_eff = linked ? s.csn_s2 : 1'b1;
    n.csn_d = csn_eff;
    n.sck_d = s.sck_s2;
    n.en_d = enabled;
    en_rise = enabled && !s.en_d;
    cs_fall = s.csn_d && !csn_eff;
    cs_rise = !s.csn_d && csn_eff && s.active;
    sck_rise = !s.sck_d && s.sck_s2 && s.active && !csn_eff;
    sck_fall = s.sck_d && !s.sck_s2 && s.active && !csn_eff;
    byte_done = sck_rise && s.bit_cnt == BIT_LAST;
    done = enabled && cs_rise && s.granted;
    sub_acq_hit = sub_hit(s.sub_acq, chan_evt_in);
    sub_rel_hit = sub_hit(s.sub_rel, chan_evt_in);
    acq_req = enabled && ((wr_at(bus_in, OFS_ACQ_TASK) && bus_in.wdata[0]) ||
              sub_acq_hit || (done && s.links[LINK_END_ACQ_BIT]));
    rel_req = enabled && ((wr_at(bus_in, OFS_REL_TASK) && bus_in.wdata[0]) ||
              sub_rel_hit);

    // semaphore: release, end of transaction, acquire, then link attempt
    if (!enabled) begin
      n.owner = OWN_FREE;
      n.pend = 1'b0;
      n.active = 1'b0;
      n.granted = 1'b0;
    end else if (en_rise) begin
      n.owner = OWN_CPU;
      n.pend = 1'b0;
    end else begin
      if (rel_req && n.owner == OWN_CPU) begin
        n.owner = OWN_FREE;
      end
      if (done) begin
        n.owner = OWN_FREE;
        if (s.pend) begin
          n.owner = OWN_CPU;
          n.pend = 1'b0;
          obtained = 1'b1;
        end
      end
      if (acq_req) begin
        unique case (n.owner)
          OWN_CPU: obtained = 1'b1;
          OWN_FREE: begin
            n.owner = OWN_CPU;
            obtained = 1'b1;
          end
          OWN_LINK: n.pend = 1'b1;
          default: n.pend = s.pend;
        endcase
      end
      // an acquire in this very cycle already took a free semaphore
      if (cs_fall) begin
        n.granted = n.owner == OWN_FREE;
        if (n.owner == OWN_FREE) begin
          n.owner = OWN_LINK;
        end
      end
    end

    // transmit byte source for the byte that starts next
    tx_idx = cs_fall ? '0 : s.tx_cnt + CNT_W'(s.from_buf);
    tx_ra = AW'(s.tx_ptr) + AW'(tx_idx);
    if (cs_fall || byte_done) begin
      if (!n.granted) begin
        n.tx_next = s.ign_char;
        n.next_from_buf = 1'b0;
      end else if (tx_idx < s.tx_lim) begin
        n.tx_next = mem[tx_ra];
        n.next_from_buf = 1'b1;
      end else begin
        n.tx_next = s.ovr_char;
        n.next_from_buf = 1'b0;
        n.xstat[XST_OVREAD_BIT] = 1'b1;
      end
    end

    if (enabled && cs_fall) begin
      n.active = 1'b1;
      n.bit_cnt = '0;
      n.rx_cnt = '0;
      n.tx_cnt = '0;
      n.tx_sh = n.tx_next;
      n.from_buf = n.next_from_buf;
    end
    if (sck_rise) begin
      n.rx_sh = {s.rx_sh[6:0], s.din_s2};
      n.bit_cnt = s.bit_cnt + 3'h1;
    end
    if (byte_done && s.granted) begin
      if (s.rx_cnt < s.rx_lim) begin
        mem_we_link = 1'b1;
        mem_wa = AW'(s.rx_ptr) + AW'(s.rx_cnt);
        mem_wd = {s.rx_sh[6:0], s.din_s2};
        n.rx_cnt = s.rx_cnt + CNT_W'(1);
        rx_full = s.rx_cnt + CNT_W'(1) == s.rx_lim;
      end else begin
        n.xstat[XST_OVFLOW_BIT] = 1'b1;
      end
      if (s.from_buf) begin
        n.tx_cnt = s.tx_cnt + CNT_W'(1);
      end
    end
    // a falling edge with the bit count back at zero starts a new byte
    if (sck_fall) begin
      if (s.bit_cnt == '0) begin
        n.tx_sh = s.tx_next;
        n.from_buf = s.next_from_buf;
      end else begin
        n.tx_sh = {s.tx_sh[6:0], 1'b0};
      end
    end
    if (cs_rise) begin
      n.active = 1'b0;
      n.granted = 1'b0;
      if (s.granted) begin
        n.rx_amt = s.rx_cnt;
        n.tx_amt = s.tx_cnt;
      end
    end

    // register writes
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        OFS_SUB_ACQ: n.sub_acq = bus_in.wdata;
        OFS_SUB_REL: n.sub_rel = bus_in.wdata;
        OFS_EV_DONE: n.ev_done = s.ev_done & bus_in.wdata[0];
        OFS_EV_RXF: n.ev_rxf = s.ev_rxf & bus_in.wdata[0];
        OFS_EV_OBT: n.ev_obt = s.ev_obt & bus_in.wdata[0];
        OFS_PUB_DONE: n.pub_done = bus_in.wdata;
        OFS_PUB_RXF: n.pub_rxf = bus_in.wdata;
        OFS_PUB_OBT: n.pub_obt = bus_in.wdata;
        OFS_LINKS: n.links = bus_in.wdata & LINKS_MASK;
        OFS_IEN_SET: n.ien = s.ien | (bus_in.wdata & IRQ_MASK);
        OFS_IEN_CLR: n.ien = s.ien & ~bus_in.wdata;
        OFS_IRQ_CLR: n.irq_pend = s.irq_pend & ~bus_in.wdata;
        // a flag set by the link in this cycle survives the clear
        OFS_XSTAT: n.xstat = n.xstat &
          ~(bus_in.wdata[1:0] & ~(n.xstat & ~s.xstat));
        OFS_ENABLE: n.enable = bus_in.wdata[3:0];
        OFS_PSEL_CLK: n.psel_clk = bus_in.wdata;
        OFS_PSEL_DOUT: n.psel_dout = bus_in.wdata;
        OFS_PSEL_DIN: n.psel_din = bus_in.wdata;
        OFS_PSEL_SEL: n.psel_sel = bus_in.wdata;
        OFS_RX_PTR: n.rx_ptr = bus_in.wdata;
        OFS_RX_LIM: n.rx_lim = bus_in.wdata[CNT_W-1:0];
        OFS_RX_LIST: n.rx_list = bus_in.wdata[1:0];
        OFS_TX_PTR: n.tx_ptr = bus_in.wdata;
        OFS_TX_LIM: n.tx_lim = bus_in.wdata[CNT_W-1:0];
        OFS_TX_LIST: n.tx_list = bus_in.wdata[1:0];
        OFS_CONFIG: n.config_bits = bus_in.wdata[2:0];
        OFS_IGN_CHAR: n.ign_char = bus_in.wdata[7:0];
        OFS_OVR_CHAR: n.ovr_char = bus_in.wdata[7:0];
        OFS_BUF_IDX: n.buf_idx = bus_in.wdata[AW-1:0];
        OFS_BUF_DATA: begin
          // a link byte landing in the same cycle wins the write port
          mem_we = !mem_we_link;
          n.buf_idx = s.buf_idx + AW'(1);
        end
        default: n.buf_idx = s.buf_idx;
      endcase
    end
    if (mem_we_link) begin
      mem_we = 1'b1;
    end

    // events: hardware set wins over a clear in the same cycle
    n.ev_done = n.ev_done | done;
    n.ev_rxf = n.ev_rxf | rx_full;
    n.ev_obt = n.ev_obt | obtained;
    n.irq_pend[IRQ_DONE_BIT] = n.irq_pend[IRQ_DONE_BIT] | done;
    n.irq_pend[IRQ_RXF_BIT] = n.irq_pend[IRQ_RXF_BIT] | rx_full;
    n.irq_pend[IRQ_OBT_BIT] = n.irq_pend[IRQ_OBT_BIT] | obtained;
    n.pub[PUB_DONE].pulse = done && s.pub_done[CFG_EN_BIT];
    n.pub[PUB_DONE].chan = s.pub_done[CHANNEL_INDEX_W-1:0];
    n.pub[PUB_RXF].pulse = rx_full && s.pub_rxf[CFG_EN_BIT];
    n.pub[PUB_RXF].chan = s.pub_rxf[CHANNEL_INDEX_W-1:0];
    n.pub[PUB_OBT].pulse = obtained && s.pub_obt[CFG_EN_BIT];
    n.pub[PUB_OBT].chan = s.pub_obt[CHANNEL_INDEX_W-1:0];

    // register reads, answered in the following cycle only
    n.rd_data = '0;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        OFS_SUB_ACQ: n.rd_data = s.sub_acq;
        OFS_SUB_REL: n.rd_data = s.sub_rel;
        OFS_EV_DONE: n.rd_data = 32'(s.ev_done);
        OFS_EV_RXF: n.rd_data = 32'(s.ev_rxf);
        OFS_EV_OBT: n.rd_data = 32'(s.ev_obt);
        OFS_PUB_DONE: n.rd_data = s.pub_done;
        OFS_PUB_RXF: n.rd_data = s.pub_rxf;
        OFS_PUB_OBT: n.rd_data = s.pub_obt;
        OFS_LINKS: n.rd_data = s.links;
        OFS_IEN_SET, OFS_IEN_CLR: n.rd_data = s.ien;
        OFS_IRQ_PEND: n.rd_data = s.irq_pend;
        OFS_SEM_OWNER_STATUS: n.rd_data = 32'(s.owner == OWN_CPU ? SEM_CPU :
          s.owner == OWN_FREE ? SEM_FREE :
          s.pend ? SEM_CPU_PEND : SEM_LINK);
        OFS_XSTAT: n.rd_data = 32'(s.xstat);
        OFS_ENABLE: n.rd_data = 32'(s.enable);
        OFS_PSEL_CLK: n.rd_data = s.psel_clk;
        OFS_PSEL_DOUT: n.rd_data = s.psel_dout;
        OFS_PSEL_DIN: n.rd_data = s.psel_din;
        OFS_PSEL_SEL: n.rd_data = s.psel_sel;
        OFS_RX_PTR: n.rd_data = s.rx_ptr;
        OFS_RX_LIM: n.rd_data = 32'(s.rx_lim);
        OFS_RX_CNT: n.rd_data = 32'(s.rx_amt);
        OFS_RX_LIST: n.rd_data = 32'(s.rx_list);
        OFS_TX_PTR: n.rd_data = s.tx_ptr;
        OFS_TX_LIM: n.rd_data = 32'(s.tx_lim);
        OFS_TX_CNT: n.rd_data = 32'(s.tx_amt);
        OFS_TX_LIST: n.rd_data = 32'(s.tx_list);
        OFS_CONFIG: n.rd_data = 32'(s.config_bits);
        OFS_IGN_CHAR: n.rd_data = 32'(s.ign_char);
        OFS_OVR_CHAR: n.rd_data = 32'(s.ovr_char);
        OFS_BUF_IDX: n.rd_data = 32'(s.buf_idx);
        OFS_BUF_DATA: begin
          n.rd_data = 32'(mem[s.buf_idx]);
          n.buf_idx = s.buf_idx + AW'(1);
        end
        default: n.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.owner <= OWN_FREE;
      s.csn_s1 <= 1'b1;
      s.csn_s2 <= 1'b1;
      s.csn_d <= 1'b1;
      s.psel_clk <= RST_PSEL;
      s.psel_dout <= RST_PSEL;
      s.psel_din <= RST_PSEL;
      s.psel_sel <= RST_PSEL;
    end else begin
      s <= n;
    end
  end

  // buffer memory carries no reset; software fills it before use
  always_ff @(posedge sys_clk_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign rd_data_out = s.rd_data;
  assign pub_out = s.pub;
  assign dout_out = s.tx_sh[7];
  assign dout_oe_out = s.active && !s.psel_dout[PSEL_DISC_BIT];
  assign irq_out = |(s.irq_pend & s.ien);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_release_frees: assert property (rel_req && s.owner == OWN_CPU &&
    !acq_req && !en_rise |=> s.owner != OWN_CPU)
    else $error("release left semaphore with cpu");
  chk_sub_acquire: assert property (sub_acq_hit && enabled && !en_rise &&
    s.owner == OWN_FREE |=> s.owner == OWN_CPU && s.ev_obt)
    else $error("subscribed acquire not served");
  chk_sub_release: assert property (sub_rel_hit && enabled && !acq_req &&
    !en_rise && s.owner == OWN_CPU |=> s.owner != OWN_CPU)
    else $error("subscribed release not served");
  chk_rx_full: assert property (byte_done && s.granted &&
    s.rx_cnt + CNT_W'(1) == s.rx_lim |=> s.ev_rxf && s.irq_pend[IRQ_RXF_BIT])
    else $error("receive full event missing");
  chk_pub_done: assert property (done |=> s.pub[PUB_DONE].pulse ==
    $past(s.pub_done[CFG_EN_BIT]) ##1 !s.pub[PUB_DONE].pulse)
    else $error("done publish wrong");
  chk_links_acq: assert property (done && s.links[LINK_END_ACQ_BIT]
    |=> s.owner == OWN_CPU && s.ev_obt)
    else $error("done to acquire chain failed");
  chk_ignored_char: assert property ($rose(s.active) && !s.granted
    |-> s.tx_sh == $past(s.ign_char))
    else $error("ignored transaction not sending fill char");
  chk_rx_limit: assert property (mem_we_link |-> s.rx_cnt < s.rx_lim)
    else $error("receive write past limit");
  chk_tx_limit: assert property (byte_done && s.from_buf && s.granted
    |-> s.tx_cnt < s.tx_lim)
    else $error("transmit fetch past limit");
  chk_amount_latch: assert property (done |=> s.rx_amt == $past(s.rx_cnt)
    && s.tx_amt == $past(s.tx_cnt))
    else $error("amounts not latched at end");
  chk_tx_uncounted: assert property (byte_done && !s.from_buf
    |=> s.tx_cnt == $past(s.tx_cnt))
    else $error("fill byte counted as sent");
  chk_dout_select: assert property (dout_oe_out |->
    s.active && !s.psel_dout[PSEL_DISC_BIT])
    else $error("data output driven while not selected");
  chk_ignore_rx: assert property (s.active && !s.granted |-> !mem_we_link)
    else $error("ignored transaction wrote buffer");
  chk_end_free: assert property (done && !s.pend && !acq_req
    |=> s.owner == OWN_FREE && s.ev_done)
    else $error("end did not free semaphore");
  chk_enable_cpu: assert property (en_rise |=> s.owner == OWN_CPU &&
    s.ev_obt == $past(s.ev_obt))
    else $error("enable handover wrong");
  chk_cpu_wins: assert property (cs_fall && acq_req |=> !s.granted)
    else $error("link won a race with the cpu");
  chk_overread: assert property (byte_done && s.granted &&
    s.tx_cnt + CNT_W'(s.from_buf) >= s.tx_lim |=>
    s.tx_next == $past(s.ovr_char))
    else $error("overrun char not chosen");
  chk_event_clear: assert property (wr_at(bus_in, OFS_EV_DONE) &&
    !bus_in.wdata[0] && !done |=> !s.ev_done)
    else $error("event not cleared by zero write");

  cov_granted: cover property (done);
  cov_ignored: cover property (cs_rise && !s.granted);
  cov_overread: cover property (byte_done && s.granted && !s.from_buf);
  cov_pending: cover property (done && s.pend);
endmodule : sps_slave
`default_nettype wire

// >>> tb/sps_master.sv
/*
  behavioural serial master for the slave bench: mode 0, msb first
  assumes the caller spaces frames; the clock stands still between them
*/
`timescale 1ns/10ps
`default_nettype none
module sps_master (
  output logic sck_out,
  output logic csn_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  initial begin
    sck_out = 1'b0;
    csn_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // bytes are left aligned in tx; rx collects the reply right aligned
  task automatic frame(input int n, input logic [31:0] tx,
                       output logic [31:0] rx);
    rx = '0;
    csn_n_out = 1'b0;
    #80;
    for (int k = 0; k < n * 8; k++) begin
      mosi_out = tx[31-k];
      #40 sck_out = 1'b1;
      rx = {rx[30:0], miso_in};
      #40 sck_out = 1'b0;
    end
    #80 csn_n_out = 1'b1;
    // released line shows the inverse so a stale bit is never trusted
    mosi_out = ~mosi_out;
    #100;
  endtask : frame
endmodule : sps_master
`default_nettype wire

// >>> tb/tb.sv
/*
  self-checking bench for the serial slave: register rows, then ungranted,
  granted, semaphore and shortcut cases; assumes sps_master drives the link
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sps_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [31:0] d;
  } sps_row_type;
  logic clk = 1'b0, rst_n = 1'b0, sck, csn_n, mosi, dout, oe, irq;
  sps_bus_type bus = '0;
  logic [31:0] rdata, rx;
  logic [255:0] evt = '0;
  sps_pub_type [2:0] pub;
  int n_mismatch = 0, checked = 0, n_pub[3] = '{0, 0, 0};
  logic [7:0] pch[3];
  // reads expect d, writes store d
  sps_row_type rows [0:30] = '{
    '{0, OFS_SUB_ACQ, 0}, '{0, OFS_PSEL_DOUT, 32'hFFFFFFFF},
    '{1, OFS_SUB_ACQ, 32'h80000005}, '{0, OFS_SUB_ACQ, 32'h80000005},
    '{1, OFS_PSEL_DOUT, 0}, '{1, OFS_PSEL_CLK, 0}, '{1, OFS_PSEL_DIN, 0},
    '{1, OFS_PSEL_SEL, 0}, '{0, OFS_PSEL_DOUT, 0}, '{0, OFS_PSEL_CLK, 0},
    '{1, OFS_IGN_CHAR, 32'hA5}, '{1, OFS_OVR_CHAR, 32'h3C},
    '{1, OFS_RX_LIM, 2}, '{1, OFS_TX_LIM, 1}, '{0, OFS_RX_LIM, 2},
    '{0, OFS_TX_LIM, 1}, '{1, OFS_RX_PTR, 32'h10}, '{1, OFS_TX_PTR, 32'h20},
    '{1, OFS_PUB_DONE, 32'h80000007}, '{1, OFS_PUB_RXF, 32'h80000008},
    '{1, OFS_PUB_OBT, 32'h80000009}, '{1, OFS_SUB_REL, 32'h80000003},
    '{1, OFS_IEN_SET, 32'h2}, '{1, OFS_BUF_IDX, 32'h20},
    '{1, OFS_BUF_DATA, 32'h11}, '{0, 12'h7F0, 0}, '{0, OFS_SEM_OWNER_STATUS, 0},
    '{1, OFS_ENABLE, 2}, '{0, OFS_SEM_OWNER_STATUS, 1}, '{0, OFS_EV_OBT, 0},
    '{0, OFS_ACQ_TASK, 0}};
  always #5 clk = ~clk;
  // an undriven output line reads as the inverse of its last value
  wire logic miso = oe ? dout : ~dout;
  sps_slave i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .bus_in(bus),
    .rd_data_out(rdata), .chan_evt_in(evt), .pub_out(pub), .sck_in(sck),
    .chip_select_n_in(csn_n), .din_in(mosi), .dout_out(dout),
    .dout_oe_out(oe), .irq_out(irq));
  sps_master i_mst (.sck_out(sck), .csn_n_out(csn_n), .mosi_out(mosi),
    .miso_in(miso));
  // sampled mid-cycle so a pulse is seen while it stands, not at its launch
  always @(negedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (pub[i].pulse === 1'b1) begin
        n_pub[i]++;
        pch[i] = pub[i].chan;
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) bus <= '0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 0};
    @(posedge clk) bus <= '0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  task automatic pulse_chan(input int c);
    @(posedge clk) evt <= 256'h1 << c;
    @(posedge clk) evt <= '0;
    repeat (2) @(posedge clk);
  endtask : pulse_chan
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, {31'h0, exp});
  endtask : irq_chk
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #200us n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr_reg(rows[i].a, rows[i].d);
      else rd_chk(rows[i].a, rows[i].d);
    end
    // cpu holds the semaphore; releasing mid-frame must not grant it
    fork
      i_mst.frame(2, 32'h81420000, rx);
      begin
        #300;
        wr_reg(OFS_REL_TASK, 1);
      end
    join
    chk(rx, 32'h0000A5A5);
    rd_chk(OFS_EV_DONE, 0);
    rd_chk(OFS_SEM_OWNER_STATUS, 0);
    // three bytes against limits of two in and one out
    i_mst.frame(3, 32'h81429900, rx);
    chk(rx, 32'h00113C3C);
    rd_chk(OFS_EV_DONE, 1);
    rd_chk(OFS_SEM_OWNER_STATUS, 0);
    rd_chk(OFS_RX_CNT, 2);
    rd_chk(OFS_TX_CNT, 1);
    rd_chk(OFS_EV_RXF, 1);
    rd_chk(OFS_XSTAT, 3);
    wr_reg(OFS_BUF_IDX, 32'h10);
    rd_chk(OFS_BUF_DATA, 32'h81);
    rd_chk(OFS_BUF_DATA, 32'h42);
    chk(n_pub[0] + n_pub[1], 2);
    chk({pch[0], pch[1]}, 32'h0708);
    irq_chk(1'b1);
    wr_reg(OFS_IEN_CLR, 32'h2);
    irq_chk(1'b0);
    wr_reg(OFS_IEN_SET, 32'h2);
    irq_chk(1'b1);
    wr_reg(OFS_IRQ_CLR, 32'h2);
    irq_chk(1'b0);
    // semaphore through channels, tasks and the event register
    pulse_chan(5);
    rd_chk(OFS_SEM_OWNER_STATUS, 1);
    rd_chk(OFS_EV_OBT, 1);
    chk({n_pub[2][7:0], pch[2]}, 32'h0109);
    wr_reg(OFS_EV_OBT, 0);
    rd_chk(OFS_EV_OBT, 0);
    wr_reg(OFS_ACQ_TASK, 1);
    rd_chk(OFS_EV_OBT, 1);
    pulse_chan(3);
    rd_chk(OFS_SEM_OWNER_STATUS, 0);
    // done event chained to acquire hands the cpu the semaphore
    wr_reg(OFS_LINKS, 32'h4);
    i_mst.frame(1, 32'h5A000000, rx);
    rd_chk(OFS_SEM_OWNER_STATUS, 1);
    rd_chk(OFS_LINKS, 32'h4);
    // reset mid-run returns semaphore, pin selects and interrupt to idle
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(OFS_SEM_OWNER_STATUS, 0);
    rd_chk(OFS_PSEL_DOUT, 32'hFFFFFFFF);
    chk({31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule : tb
`default_nettype wire
